// ---- verilog/csrs_sequencer.sv ----
// clock source select and reset start-up sequencer with apb configuration
// Function
// - hold internal clock, ignoring external source, until start-up finishes
// - after start-up switch to source chosen by clock mode option bit 0
// - internal oscillator frequency trimmed by a calibration option byte
// - external mode: selected clock follows oscillator input pin period and phase
// - separate cpu and peripheral clocks; cpu divided up to 64
// - four reset sources; any one restarts program from the start
// - reset pin is input only, never driven
// - external reset acts at once, unqualified
// - after pin or power-on reset wait for supply threshold indication
// - then start internal oscillator and count 4096 cycles
// - internal mode starts at once; else read wake prescale, second count
// - second count lasts 4096 times (prescale plus one) cycles
// - low-voltage or watchdog reset skips both counts, oscillator kept running
// - core first fetches the three-byte jump at program memory start
// - divide code: zero none, one-hot 2..64, others 64
// - clock source bit: 0 internal oscillator, 1 external clock or quartz
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module csrs_sequencer (
	input wire logic pclk, // system clock, 50 mhz
	input wire logic presetn, // async reset, active low
	input wire csrs_pkg::csrs_apb_req_t apb_req, // apb request group
	output csrs_pkg::csrs_apb_rsp_t apb_rsp, // apb answer group
	input wire csrs_pkg::csrs_rst_src_t rst_src, // reset sources
	input wire logic supply_ok, // supply above start threshold
	input wire logic osc_input_pin, // oscillator input pin level
	output logic osc_output_pin, // oscillator feedback drive
	output logic int_osc_enable, // internal oscillator run
	output logic [7:0] oscillator_trim_option, // trim to internal oscillator
	output logic [csrs_pkg::CSRS_GAIN_W-1:0] osc_gain, // gain stages to crystal amp
	output logic clock_source_select, // applied source, 1 external
	output logic clock_out, // selected clock as level
	output logic periph_clk_en, // peripheral clock enable
	output logic cpu_clk_en, // cpu clock enable after divider
	output logic core_reset_n, // internal reset to core, active low
	output logic fetch_start, // pulse: first fetch begins
	output logic [15:0] fetch_addr, // first fetch address
	output logic [1:0] fetch_len // bytes in first fetch
);
	import csrs_pkg::*;

	csrs_state_t state;
	csrs_state_t next_state;
	logic [5:0] cpu_divide_code;
	logic [7:0] clock_mode_option;
	logic [7:0] gain_option;
	logic [7:0] prescale_option_a;
	logic [7:0] wake_latched;
	logic [19:0] count;
	logic [19:0] wake_target;
	logic any_reset;
	logic cold_reset;
	logic cold_seen;
	logic [1:0] rel_sync;
	logic int_clk;
	logic applied_ext;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic cpu_tick;
	logic [31:0] rdata_q;
	logic slv_err;

	// sources: pin acts combinationally so no delay is added
	assign any_reset = !rst_src.ext_pin_n || rst_src.watchdog || rst_src.power_on
		|| rst_src.low_voltage;
	assign cold_reset = !rst_src.ext_pin_n || rst_src.power_on;

	// apb decode; zero wait states
	assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_en = apb_req.psel && !apb_req.pwrite;
	always_comb begin
		unique case (apb_req.paddr)
			CSRS_ADDR_CPU_CLK, CSRS_ADDR_OPT_MODE, CSRS_ADDR_OPT_TRIM,
			CSRS_ADDR_OPT_GAIN, CSRS_ADDR_OPT_WAKE, CSRS_ADDR_STATUS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	// whole answer group driven by one assignment so the struct has a single driver
	assign slv_err = apb_req.psel && apb_req.penable && !addr_ok;
	assign apb_rsp = '{pready: 1'b1, pslverr: slv_err, prdata: rdata_q};

	// read data registered in setup so it stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= CSRS_RDATA_ZERO;
		end else if (rd_en && !apb_req.penable) begin
			unique case (apb_req.paddr)
				CSRS_ADDR_CPU_CLK: rdata_q <= {26'h0, cpu_divide_code};
				CSRS_ADDR_OPT_MODE: rdata_q <= {24'h0, clock_mode_option};
				CSRS_ADDR_OPT_TRIM: rdata_q <= {24'h0, oscillator_trim_option};
				CSRS_ADDR_OPT_GAIN: rdata_q <= {24'h0, gain_option};
				CSRS_ADDR_OPT_WAKE: rdata_q <= {24'h0, prescale_option_a};
				CSRS_ADDR_STATUS: rdata_q <= {26'h0, applied_ext, core_reset_n, cold_seen, state};
				default: rdata_q <= CSRS_RDATA_ZERO;
			endcase
		end
	end

	// cpu divider config register; survives internal resets, cleared by presetn
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_divide_code <= CSRS_RST_CPU_DIV;
		end else if (wr_en && apb_req.paddr == CSRS_ADDR_CPU_CLK) begin
			cpu_divide_code <= apb_req.pwdata[5:0];
		end
	end

	// option byte images; software programs them like nonvolatile option bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_mode_option <= CSRS_RST_OPT;
			oscillator_trim_option <= CSRS_RST_OPT;
			gain_option <= CSRS_RST_OPT;
			prescale_option_a <= CSRS_RST_OPT;
		end else if (wr_en) begin
			if (apb_req.paddr == CSRS_ADDR_OPT_MODE) begin
				clock_mode_option <= apb_req.pwdata[7:0];
			end
			if (apb_req.paddr == CSRS_ADDR_OPT_TRIM) begin
				oscillator_trim_option <= apb_req.pwdata[7:0];
			end
			if (apb_req.paddr == CSRS_ADDR_OPT_GAIN) begin
				gain_option <= apb_req.pwdata[7:0]; // gain is software's duty
			end
			if (apb_req.paddr == CSRS_ADDR_OPT_WAKE) begin
				prescale_option_a <= apb_req.pwdata[7:0];
			end
		end
	end

	// remembers that a cold reset was seen, so release needs the supply check
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cold_seen <= 1'b1;
		end else if (cold_reset) begin
			cold_seen <= 1'b1;
		end else if (state == CSRS_ST_RUN) begin
			cold_seen <= 1'b0;
		end
	end

	// last count of the second delay, 4096 * (prescale + 1) - 1; written this way so
	// the largest prescale still fits the 20-bit counter instead of wrapping to zero
	assign wake_target = {wake_latched, 12'h000} + ({7'h00, CSRS_STARTUP_CYCLES} - CSRS_CNT_ONE);

	// sequencer next state
	always_comb begin
		next_state = state;
		unique case (state)
			CSRS_ST_HOLD: begin
				if (!any_reset) begin
					// warm resets keep the oscillator running and skip both counts
					next_state = cold_seen ? CSRS_ST_SUPPLY : CSRS_ST_RUN;
				end
			end
			CSRS_ST_SUPPLY: begin
				if (supply_ok) begin
					next_state = CSRS_ST_OSC;
				end
			end
			CSRS_ST_OSC: begin
				if (count == {7'h00, CSRS_STARTUP_CYCLES} - CSRS_CNT_ONE) begin
					next_state = clock_mode_option[CSRS_BIT_CLK_SRC] ? CSRS_ST_WAKE : CSRS_ST_RUN;
				end
			end
			CSRS_ST_WAKE: begin
				if (count == wake_target) begin
					next_state = CSRS_ST_RUN;
				end
			end
			CSRS_ST_RUN: begin
				next_state = CSRS_ST_RUN;
			end
			default: next_state = CSRS_ST_HOLD;
		endcase
		if (any_reset) begin
			next_state = CSRS_ST_HOLD;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CSRS_ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// start-up counter, cleared on every state change and while reset is held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= CSRS_CNT_ZERO;
		end else if (any_reset || next_state != state) begin
			count <= CSRS_CNT_ZERO;
		end else if (state == CSRS_ST_OSC || state == CSRS_ST_WAKE) begin
			count <= count + CSRS_CNT_ONE;
		end
	end

	// prescale is read once at the end of the first count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_latched <= CSRS_RST_OPT;
		end else if (state == CSRS_ST_OSC && next_state == CSRS_ST_WAKE) begin
			wake_latched <= prescale_option_a;
		end
	end

	// applied source switches only in run; internal clock until then
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			applied_ext <= 1'b0;
		end else if (state != CSRS_ST_RUN) begin
			applied_ext <= 1'b0;
		end else begin
			applied_ext <= clock_mode_option[CSRS_BIT_CLK_SRC];
		end
	end

	// internal oscillator modelled as a toggle of the system clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_clk <= 1'b0;
		end else begin
			int_clk <= ~int_clk;
		end
	end

	// release through two flops so core reset leaves on a clock edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rel_sync <= 2'b00;
		end else if (state != CSRS_ST_RUN) begin
			rel_sync <= 2'b00;
		end else begin
			rel_sync <= {rel_sync[0], 1'b1};
		end
	end
	assign core_reset_n = rel_sync[1] && !any_reset; // assert is immediate

	// first fetch of the reset jump at the start of program memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_start <= 1'b0;
		end else begin
			fetch_start <= rel_sync[0] && !rel_sync[1] && !any_reset;
		end
	end
	assign fetch_addr = CSRS_RESET_VECTOR;
	assign fetch_len = CSRS_VECTOR_BYTES;

	// external mode follows the pin directly, keeping its period and phase
	assign clock_out = applied_ext ? osc_input_pin : int_clk;
	assign clock_source_select = applied_ext;
	// oscillator stays on through warm resets; off only while a cold reset waits
	assign int_osc_enable = !(state == CSRS_ST_HOLD && cold_seen) && state != CSRS_ST_SUPPLY;
	assign osc_gain = gain_option[CSRS_GAIN_W-1:0];
	assign osc_output_pin = clock_mode_option[CSRS_BIT_CLK_SRC] && (osc_gain != '0) && !osc_input_pin;
	assign periph_clk_en = core_reset_n; // peripherals run undivided
	assign cpu_clk_en = cpu_tick;
	// the reset pin has no output here at all: input only

	csrs_divider u_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(core_reset_n),
		.cpu_divide_code(cpu_divide_code),
		.cpu_tick(cpu_tick)
	);
endmodule

// ---- verilog/csrs_pkg.sv ----
// package for the clock select and reset sequencer: offsets, fields, timing, types
package csrs_pkg;
	// apb register byte addresses
	localparam logic [11:0] CSRS_ADDR_CPU_CLK = 12'h0b8; // cpu divider config register 02eh, word index 46
	localparam logic [11:0] CSRS_ADDR_OPT_MODE = 12'h100; // clock mode option byte image
	localparam logic [11:0] CSRS_ADDR_OPT_TRIM = 12'h104; // oscillator trim option byte image
	localparam logic [11:0] CSRS_ADDR_OPT_GAIN = 12'h108; // oscillator gain option byte image
	localparam logic [11:0] CSRS_ADDR_OPT_WAKE = 12'h10c; // wake-up prescale option byte image
	localparam logic [11:0] CSRS_ADDR_STATUS = 12'h110; // sequencer status, read only
	// reset values
	localparam logic [5:0] CSRS_RST_CPU_DIV = 6'h00;
	localparam logic [7:0] CSRS_RST_OPT = 8'h00;
	// field positions
	localparam int CSRS_BIT_CLK_SRC = 0; // clock_source_select in clock mode option
	localparam int CSRS_GAIN_W = 3;
	localparam int CSRS_DIV_W = 6;
	// timing: start-up count in oscillator cycles
	localparam logic [12:0] CSRS_STARTUP_CYCLES = 13'h1000; // 4096
	localparam logic [19:0] CSRS_CNT_ONE = 20'h00001;
	localparam logic [19:0] CSRS_CNT_ZERO = 20'h00000;
	localparam logic [6:0] CSRS_DIV_MAX = 7'h40; // divide by 64
	localparam logic [31:0] CSRS_RDATA_ZERO = 32'h0000_0000;
	// reset entry vector: first three bytes of program memory hold a jump
	localparam logic [15:0] CSRS_RESET_VECTOR = 16'h0000;
	localparam logic [1:0] CSRS_VECTOR_BYTES = 2'h3;

	typedef enum logic [2:0] {
		CSRS_ST_HOLD = 3'b000, // some reset source asserted
		CSRS_ST_SUPPLY = 3'b001, // waiting for supply threshold
		CSRS_ST_OSC = 3'b010, // first 4096-cycle count
		CSRS_ST_WAKE = 3'b011, // second prescaled count
		CSRS_ST_RUN = 3'b100 // core released
	} csrs_state_t;

	// apb request and answer carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} csrs_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} csrs_apb_rsp_t;

	// reset source group
	typedef struct packed {
		logic ext_pin_n; // external reset pin level
		logic watchdog; // watchdog reset request
		logic power_on; // power-on detector
		logic low_voltage; // low_voltage_detector output
	} csrs_rst_src_t;
endpackage

// ---- verilog/csrs_divider.sv ----
// cpu clock enable divider driven by the 6-bit divide code
`timescale 1ns/1ps
module csrs_divider (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic run, // divider runs only while core released
	input wire logic [csrs_pkg::CSRS_DIV_W-1:0] cpu_divide_code, // divide code
	output logic cpu_tick // one-cycle cpu clock enable
);
	import csrs_pkg::*;

	logic [6:0] ratio;
	logic [6:0] count;

	// decode code to ratio; zero gives 1, other non one-hot codes fall back to 64
	always_comb begin
		ratio = CSRS_DIV_MAX;
		if (cpu_divide_code == '0) begin
			ratio = 7'h01;
		end else if ($onehot(cpu_divide_code)) begin
			ratio = 7'h01;
			for (int i = 0; i < CSRS_DIV_W; i++) begin
				if (cpu_divide_code[i]) begin
					ratio = 7'(2 << i);
				end
			end
		end
	end

	// count restarts on every tick; the ratio is compared live, so a new code also changes the period in progress
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 7'h00;
		end else if (!run || count >= ratio - 7'h01) begin
			count <= 7'h00;
		end else begin
			count <= count + 7'h01;
		end
	end

	assign cpu_tick = run && (count >= ratio - 7'h01);
endmodule

// ---- verification/csrs_ext_model.sv ----
// far-side model: reset pin with pull-up and an external oscillator input
`timescale 1ns/1ps
module csrs_ext_model (
	input wire logic pclk, // system clock
	input wire logic hold_low, // bench asks for the pin low
	output logic ext_pin_n, // reset pin level
	output logic osc_in // oscillator input level
);
	logic [1:0] ph = 2'h0;
	logic tog = 1'b0;
	assign osc_in = tog;
	// pin rests at the pull-up level in normal operation
	assign ext_pin_n = !hold_low;
	// slower than the internal toggle so a wrong mux choice shows
	always @(posedge pclk) begin
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		if (ph == 2'h0) tog <= !tog;
	end
endmodule

// ---- verification/csrs_checker.sv ----
// checker: start-up, release and clock routing relations at the sequencer ports
`timescale 1ns/1ps
module csrs_checker (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire csrs_pkg::csrs_rst_src_t rst_src, // reset sources
	input wire logic supply_ok, // supply adequate
	input wire logic osc_input_pin, // oscillator input
	input wire logic osc_output_pin, // oscillator drive
	input wire logic [2:0] osc_gain, // gain stages
	input wire logic int_osc_enable, // internal oscillator run
	input wire logic clock_source_select, // applied source
	input wire logic clock_out, // selected clock
	input wire logic periph_clk_en, // peripheral enable
	input wire logic cpu_clk_en, // cpu enable
	input wire logic core_reset_n, // core reset, active low
	input wire logic fetch_start, // first fetch pulse
	input wire logic [15:0] fetch_addr, // first fetch address
	input wire logic [1:0] fetch_len // first fetch bytes
);
	import csrs_pkg::*;
	logic src;
	logic cold;
	logic [12:0] cnt;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign src = !rst_src.ext_pin_n | rst_src.watchdog | rst_src.power_on | rst_src.low_voltage;
	// cold path pending until the first fetch after it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cold <= 1'b1;
		else if (!rst_src.ext_pin_n | rst_src.power_on) cold <= 1'b1;
		else if (fetch_start) cold <= 1'b0;
	end
	// cycles since every source released, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt <= 13'h0000;
		else if (src) cnt <= 13'h0000;
		else if (cnt != 13'h1fff) cnt <= cnt + 13'h0001;
	end
	property p_src_hold; src |-> !core_reset_n; endproperty
	a_src_hold: assert property (p_src_hold) else $error("core released with a source asserted");
	property p_cold_count; $rose(core_reset_n) && cold |-> cnt > 13'h1000; endproperty
	a_cold_count: assert property (p_cold_count) else $error("cold start shorter than count");
	property p_cold_supply; cold && !supply_ok |-> !core_reset_n; endproperty
	a_cold_supply: assert property (p_cold_supply) else $error("start without supply");
	property p_warm; $fell(rst_src.watchdog) && !src && !cold |-> ##[1:4] core_reset_n; endproperty
	a_warm: assert property (p_warm) else $error("warm restart delayed");
	property p_fetch; $rose(core_reset_n) |-> fetch_start && fetch_addr == 16'h0000 && fetch_len == 2'h3; endproperty
	a_fetch: assert property (p_fetch) else $error("first fetch wrong");
	property p_clk_en; cpu_clk_en |-> periph_clk_en && core_reset_n; endproperty
	a_clk_en: assert property (p_clk_en) else $error("cpu enable while held");
	property p_ext_follow; clock_source_select |-> clock_out == osc_input_pin; endproperty
	a_ext_follow: assert property (p_ext_follow) else $error("clock not following pin");
	property p_int_first; $rose(clock_source_select) && cold |-> cnt > 13'h1000; endproperty
	a_int_first: assert property (p_int_first) else $error("external clock before start-up");
	property p_gain0; osc_gain == 3'h0 |-> !osc_output_pin; endproperty
	a_gain0: assert property (p_gain0) else $error("oscillator driven with no gain");
	// a warm source must not stop the oscillator, or the immediate restart is lost
	property p_osc_warm; src && !cold |-> int_osc_enable; endproperty
	a_osc_warm: assert property (p_osc_warm) else $error("oscillator stopped on warm reset");
	cover property ($rose(core_reset_n) && cold);
	cover property ($fell(rst_src.watchdog) && !cold);
	cover property ($rose(clock_source_select));
endmodule
bind csrs_sequencer csrs_checker csrs_checker_inst (.pclk, .presetn, .rst_src, .supply_ok, .osc_input_pin,
	.osc_output_pin, .osc_gain, .int_osc_enable, .clock_source_select, .clock_out, .periph_clk_en, .cpu_clk_en,
	.core_reset_n, .fetch_start, .fetch_addr, .fetch_len);

// ---- verification/tb_clock_select_reset_sequencer.sv ----
// testbench: apb set-up, cold and warm start-up, divider ratios
`timescale 1ns/1ps
module tb_clock_select_reset_sequencer;
	import csrs_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	csrs_apb_req_t req = '0;
	csrs_apb_rsp_t rsp;
	logic supply_ok = 1'b1;
	logic hold = 1'b0;
	logic wdog = 1'b0;
	logic pon = 1'b0;
	logic lvd = 1'b0;
	logic ext_n, osc_in, osc_out, cs, cpu_en, core_n, osc_en;
	logic [7:0] trim;
	logic [2:0] gain;
	logic [32:0] exp_q[$];
	int num_errors = 0;
	int n_tests = 0;
	int seed, cyc, g, i;
	logic [7:0] r;
	logic [5:0] codes[8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h06};
	always #10 pclk = ~pclk;
	csrs_ext_model csrs_ext_model_inst (.pclk(pclk), .hold_low(hold), .ext_pin_n(ext_n), .osc_in(osc_in));
	csrs_sequencer csrs_sequencer_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.rst_src({ext_n, wdog, pon, lvd}), .supply_ok(supply_ok), .osc_input_pin(osc_in),
		.osc_output_pin(osc_out), .int_osc_enable(osc_en), .oscillator_trim_option(trim), .osc_gain(gain),
		.clock_source_select(cs), .clock_out(), .periph_clk_en(), .cpu_clk_en(cpu_en),
		.core_reset_n(core_n), .fetch_start(), .fetch_addr(), .fetch_len());
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [32:0] exp, input logic [32:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	// one apb transfer; the master waits for pready for up to 50 cycles, then counts an error and ends the run
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin @(posedge pclk); n++; end while (rsp.pready !== 1'b1 && n < 50);
		if (n >= 50) begin num_errors++; wrap_up(); end
		req <= '0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] exp);
		exp_q.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wait_core(output int c);
		c = 0;
		do begin @(posedge pclk); c++; end while (core_n !== 1'b1 && c < 20000);
		if (c >= 20000) begin num_errors++; wrap_up(); end
	endtask
	task automatic gap_of(output int n);
		int k = 0;
		n = 0;
		while (cpu_en !== 1'b1 && k < 200) begin @(posedge pclk); k++; end
		do begin @(posedge pclk); n++; end while (cpu_en !== 1'b1 && n < 200);
	endtask
	// read answers are taken at the completing edge and matched against the oldest note
	always @(posedge pclk) begin
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
			if (exp_q.size() == 0) chk(33'h0, {rsp.pslverr, rsp.prdata});
			else chk(exp_q.pop_front(), {rsp.pslverr, rsp.prdata});
		end
	end
	// a hang is cut short here
	initial begin
		repeat (100000) @(posedge pclk);
		num_errors++;
		wrap_up();
	end
	initial begin
		seed = 82;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		wait_core(cyc);
		chk(33'(cyc >= 4096 && cyc < 4112), 33'h1);
		chk(33'(cs), 33'h0);
		r = 8'($random(seed));
		apb(1'b1, CSRS_ADDR_OPT_TRIM, {24'h0, r});
		apb(1'b1, CSRS_ADDR_OPT_MODE, 32'h1);
		apb(1'b1, CSRS_ADDR_OPT_GAIN, 32'h3);
		apb(1'b1, CSRS_ADDR_OPT_WAKE, 32'h1);
		rd(CSRS_ADDR_OPT_TRIM, {25'h0, r});
		rd(12'h0fc, 33'h1_0000_0000);
		// power-on restart, external mode: both counts run
		pon <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(33'(core_n), 33'h0);
		pon <= 1'b0;
		wait_core(cyc);
		chk(33'(cyc >= 12288 && cyc < 12304), 33'h1);
		chk({32'h0, cs}, 33'h1);
		chk({25'h0, trim}, {25'h0, r});
		chk({30'h0, gain}, 33'h3);
		chk({32'h0, osc_out}, {32'h0, ~osc_in});
		apb(1'b1, CSRS_ADDR_OPT_GAIN, 32'h0);
		// the write lands at the completing edge; look once it has settled
		@(posedge pclk);
		chk({32'h0, osc_out}, 33'h0);
		// pin reset, supply not yet adequate
		supply_ok <= 1'b0;
		hold <= 1'b1;
		repeat (5) @(posedge pclk);
		hold <= 1'b0;
		repeat (200) @(posedge pclk);
		chk({32'h0, core_n}, 33'h0);
		chk({32'h0, osc_en}, 33'h0);
		supply_ok <= 1'b1;
		wait_core(cyc);
		chk(33'(cyc >= 12288 && cyc < 12304), 33'h1);
		// warm sources restart at once
		for (i = 0; i < 2; i++) begin
			if (i == 0) wdog <= 1'b1;
			else lvd <= 1'b1;
			repeat (2) @(posedge pclk);
			chk({32'h0, core_n}, 33'h0);
			chk({32'h0, osc_en}, 33'h1);
			wdog <= 1'b0;
			lvd <= 1'b0;
			wait_core(cyc);
			chk(33'(cyc < 8), 33'h1);
		end
		// divider codes: none, one-hot, and an illegal mix
		for (i = 0; i < 8; i++) begin
			apb(1'b1, CSRS_ADDR_CPU_CLK, {26'h0, codes[i]});
			rd(CSRS_ADDR_CPU_CLK, {27'h0, codes[i]});
			gap_of(g);
			gap_of(g);
			chk(33'(g), (i == 7) ? 33'd64 : 33'(1 << i));
		end
		// status after a warm restart in external mode: ext, released, no cold, run
		rd(CSRS_ADDR_STATUS, 33'h34);
		wrap_up();
	end
endmodule
